/* File: slgm_pkg.sv */
// Package of constants and types for the serial link pin mapper
package slgm_pkg;

    // ****************************************************************
    // Register map: word indices, the byte address is four times the index
    // ****************************************************************
    localparam logic [7:0] SLGM_INPUT_CTL_ADDR  = 8'h0F;
    localparam logic [7:0] SLGM_BC_SEL_LO_ADDR  = 8'h6E;
    localparam logic [7:0] SLGM_BC_SEL_HI_ADDR  = 8'h6F;
    localparam logic [7:0] SLGM_PD_CTL_ADDR     = 8'hBE;
    localparam logic [7:0] SLGM_PIN_CFG0_ADDR   = 8'h10;
    localparam logic [7:0] SLGM_FWD_CNT_ADDR    = 8'h18;
    localparam logic [7:0] SLGM_STATUS_ADDR     = 8'h1C;
    localparam logic [7:0] SLGM_PORT_SEL_ADDR   = 8'h20;
    localparam logic [7:0] SLGM_BC_DIV_ADDR     = 8'h24;

    // ****************************************************************
    // Sizes and reset values
    // ****************************************************************
    localparam int         SLGM_NUM_PINS   = 7;
    localparam int         SLGM_NUM_PORTS  = 2;
    localparam int         SLGM_NUM_FWD    = 4;
    localparam int         SLGM_NUM_SLOTS  = 4;
    localparam logic [6:0] SLGM_EN_RESET   = 7'h7F;
    localparam logic [7:0] SLGM_PIN_CFG_RST = 8'h00;
    localparam logic [7:0] SLGM_BC_SEL_RST = 8'h00;

    // Pin config byte: [7] output enable, [6:4] group, [3:1] sub, [0] level
    localparam int SLGM_CFG_OE    = 7;
    localparam int SLGM_CFG_GRP_L = 4;
    localparam int SLGM_CFG_SUB_L = 1;
    localparam int SLGM_CFG_LVL   = 0;

    localparam logic [2:0] SLGM_GRP_PORT0  = 3'h0;
    localparam logic [2:0] SLGM_GRP_PORT1  = 3'h1;
    localparam logic [2:0] SLGM_GRP_STATUS = 3'h4;
    localparam logic [2:0] SLGM_SUB_CONST  = 3'h0;
    localparam logic [2:0] SLGM_SUB_SYNC   = 3'h4;

    // Slot source code (4 bits): 0..6 local pin, 7 sync pulse, others low
    localparam logic [3:0] SLGM_SLOT_SYNC  = 4'h7;

    // ****************************************************************
    // Timing: 30-bit back-channel frame, 20 ns clock
    // ****************************************************************
    localparam int         SLGM_BC_FRAME_BITS = 30;
    localparam int         SLGM_CLK_NS        = 20;
    localparam int         SLGM_BC_FAST_BIT_NS = 20;
    localparam int         SLGM_BC_FAST_FRAME_NS = SLGM_BC_FAST_BIT_NS * SLGM_BC_FRAME_BITS;
    localparam int         SLGM_BC_FRAME_CYC  = SLGM_BC_FAST_FRAME_NS / SLGM_CLK_NS;
    localparam logic [4:0] SLGM_BC_DIV_RST    = 5'h0_1;

    // Forward sample period in frames by linked count
    localparam logic [2:0] SLGM_FWD_PER1 = 3'h1;
    localparam logic [2:0] SLGM_FWD_PER2 = 3'h2;
    localparam logic [2:0] SLGM_FWD_PER5 = 3'h5;

    typedef struct packed {
        logic [SLGM_NUM_SLOTS-1:0] bits;
        logic                      frame;
    } slgm_bc_frame_t;

endpackage : slgm_pkg

/* File: slgm_mapper.sv */
// Pin mapper between local pins and forward / back channel slots
`timescale 1ns/100ps

// Function
// [R1] Seven local pins may output forward values
// [R2] Four forward signals per receive port
// [R3] Any forward signal routes to any pin
// [R4] Older serializers supply no forward pins
// [R5] Forward update every 1, 2, 5 frames
// [R6] Remote source toggles below quarter rate
// [R7] Sync or status may drive any pin
// [R8] All pins start as inputs
// [R9] Four back slots per port, any pin
// [R10] One pin may feed several slots
// [R11] Back frame is thirty bits long
// [R12] Pins sampled once per back frame
// [R13] Sampling rate is bit rate over thirty
// [R14] Back pin driver switches below quarter rate
// [R15] Sync pulse selectable for any slot
// [R16] Slot selection in registers 0x6E, 0x6F
// [R17] Input and pulldown disables, enabled at reset
// [R18] Status group zero drives register level
// [R19] Output holds last forward value
module slgm_mapper
    import slgm_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic      [31:0]               hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    input  wire logic [SLGM_NUM_PINS-1:0]  pin_in,
    output logic      [SLGM_NUM_PINS-1:0]  pin_out,
    output logic      [SLGM_NUM_PINS-1:0]  pin_oe,
    output logic      [SLGM_NUM_PINS-1:0]  pin_input_en,
    output logic      [SLGM_NUM_PINS-1:0]  pin_pulldown_en,
    input  wire logic                      sensor_sync_pulse,
    input  wire logic [SLGM_NUM_PORTS-1:0] fwd_frame,
    input  wire logic [SLGM_NUM_PORTS-1:0] fwd_capable,
    input  wire logic [7:0]                fwd_bits,
    output logic      [SLGM_NUM_PORTS-1:0] bc_frame,
    output logic      [7:0]                bc_bits
);

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function automatic logic [2:0] fwd_period(input logic [2:0] cnt);
        if (cnt <= 3'h1) begin
            fwd_period = SLGM_FWD_PER1;
        end else if (cnt == 3'h2) begin
            fwd_period = SLGM_FWD_PER2;
        end else begin
            fwd_period = SLGM_FWD_PER5;
        end
    endfunction : fwd_period

    function automatic logic slot_src(input logic [3:0] sel, input logic [SLGM_NUM_PINS-1:0] lv,
                                      input logic sy);
        if (sel == SLGM_SLOT_SYNC) begin
            slot_src = sy;
        end else if (sel < 4'(SLGM_NUM_PINS)) begin
            slot_src = lv[sel[2:0]];
        end else begin
            slot_src = 1'b0;
        end
    endfunction : slot_src

    // ****************************************************************
    // Register file and AHB-Lite slave
    // ****************************************************************
    logic [7:0]  pin_cfg_reg [SLGM_NUM_PINS];
    logic [7:0]  pin_cfg_next [SLGM_NUM_PINS];
    logic [6:0]  in_dis_reg, in_dis_next;
    logic [6:0]  pd_dis_reg, pd_dis_next;
    logic [7:0]  bc_lo_reg [SLGM_NUM_PORTS];
    logic [7:0]  bc_lo_next [SLGM_NUM_PORTS];
    logic [7:0]  bc_hi_reg [SLGM_NUM_PORTS];
    logic [7:0]  bc_hi_next [SLGM_NUM_PORTS];
    logic [5:0]  fwd_cnt_reg, fwd_cnt_next;
    logic        port_sel_reg, port_sel_next;
    logic [4:0]  bc_div_reg, bc_div_next;
    logic        wr_pend_reg, wr_pend_next;
    logic [7:0]  wr_addr_reg, wr_addr_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic        addr_ok;
    logic [7:0]  a8;

    assign addr_ok = hsel && hready && htrans[1];
    // One register per word, so the byte lane bits are dropped from the index
    assign a8      = haddr[9:2];

    always_comb begin
        pin_cfg_next  = pin_cfg_reg;
        in_dis_next   = in_dis_reg;
        pd_dis_next   = pd_dis_reg;
        bc_lo_next    = bc_lo_reg;
        bc_hi_next    = bc_hi_reg;
        fwd_cnt_next  = fwd_cnt_reg;
        port_sel_next = port_sel_reg;
        bc_div_next   = bc_div_reg;
        wr_pend_next  = addr_ok && hwrite;
        wr_addr_next  = addr_ok ? a8 : wr_addr_reg;
        hrdata_next   = hrdata_reg;
        if (wr_pend_reg) begin
            if (wr_addr_reg == SLGM_INPUT_CTL_ADDR) begin
                in_dis_next = hwdata[6:0];                                 // R17
            end else if (wr_addr_reg == SLGM_PD_CTL_ADDR) begin
                pd_dis_next = hwdata[6:0];                                 // R17
            end else if (wr_addr_reg == SLGM_BC_SEL_LO_ADDR) begin
                bc_lo_next[port_sel_reg] = hwdata[7:0];                    // R16
            end else if (wr_addr_reg == SLGM_BC_SEL_HI_ADDR) begin
                bc_hi_next[port_sel_reg] = hwdata[7:0];                    // R16
            end else if (wr_addr_reg == SLGM_FWD_CNT_ADDR) begin
                fwd_cnt_next = hwdata[5:0];
            end else if (wr_addr_reg == SLGM_PORT_SEL_ADDR) begin
                port_sel_next = hwdata[0];
            end else if (wr_addr_reg == SLGM_BC_DIV_ADDR) begin
                bc_div_next = (hwdata[4:0] == 5'h0_0) ? SLGM_BC_DIV_RST : hwdata[4:0];
            end else if (wr_addr_reg[7:4] == SLGM_PIN_CFG0_ADDR[7:4] && wr_addr_reg[3:0] < 4'(SLGM_NUM_PINS)) begin
                pin_cfg_next[wr_addr_reg[2:0]] = hwdata[7:0];              // R3
            end
        end
        if (addr_ok && !hwrite) begin
            hrdata_next = 32'h0000_0000;
            if (a8 == SLGM_INPUT_CTL_ADDR) begin
                hrdata_next[6:0] = in_dis_reg;
            end else if (a8 == SLGM_PD_CTL_ADDR) begin
                hrdata_next[6:0] = pd_dis_reg;
            end else if (a8 == SLGM_BC_SEL_LO_ADDR) begin
                hrdata_next[7:0] = bc_lo_reg[port_sel_reg];
            end else if (a8 == SLGM_BC_SEL_HI_ADDR) begin
                hrdata_next[7:0] = bc_hi_reg[port_sel_reg];
            end else if (a8 == SLGM_FWD_CNT_ADDR) begin
                hrdata_next[5:0] = fwd_cnt_reg;
            end else if (a8 == SLGM_PORT_SEL_ADDR) begin
                hrdata_next[0] = port_sel_reg;
            end else if (a8 == SLGM_BC_DIV_ADDR) begin
                hrdata_next[4:0] = bc_div_reg;
            end else if (a8 == SLGM_STATUS_ADDR) begin
                hrdata_next[6:0]  = pin_in;
                hrdata_next[14:8] = pin_out;
            end else if (a8[7:4] == SLGM_PIN_CFG0_ADDR[7:4] && a8[3:0] < 4'(SLGM_NUM_PINS)) begin
                hrdata_next[7:0] = pin_cfg_reg[a8[2:0]];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < SLGM_NUM_PINS; i++) begin
                pin_cfg_reg[i] <= SLGM_PIN_CFG_RST;                        // R8
            end
            for (int p = 0; p < SLGM_NUM_PORTS; p++) begin
                bc_lo_reg[p] <= SLGM_BC_SEL_RST;
                bc_hi_reg[p] <= SLGM_BC_SEL_RST;
            end
            in_dis_reg   <= 7'h00;                                          // R17
            pd_dis_reg   <= 7'h00;
            fwd_cnt_reg  <= 6'h00;
            port_sel_reg <= 1'b0;
            bc_div_reg   <= SLGM_BC_DIV_RST;
            wr_pend_reg  <= 1'b0;
            wr_addr_reg  <= 8'h00;
            hrdata_reg   <= 32'h0000_0000;
        end else begin
            pin_cfg_reg  <= pin_cfg_next;
            bc_lo_reg    <= bc_lo_next;
            bc_hi_reg    <= bc_hi_next;
            in_dis_reg   <= in_dis_next;
            pd_dis_reg   <= pd_dis_next;
            fwd_cnt_reg  <= fwd_cnt_next;
            port_sel_reg <= port_sel_next;
            bc_div_reg   <= bc_div_next;
            wr_pend_reg  <= wr_pend_next;
            wr_addr_reg  <= wr_addr_next;
            hrdata_reg   <= hrdata_next;
        end
    end

    // Zero wait states; every response is OKAY
    assign hrdata    = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ****************************************************************
    // Forward channel sampling
    // ****************************************************************
    logic [3:0] fwd_val_reg [SLGM_NUM_PORTS];
    logic [3:0] fwd_val_next [SLGM_NUM_PORTS];
    logic [2:0] fwd_fc_reg [SLGM_NUM_PORTS];
    logic [2:0] fwd_fc_next [SLGM_NUM_PORTS];

    always_comb begin
        fwd_val_next = fwd_val_reg;
        fwd_fc_next  = fwd_fc_reg;
        for (int p = 0; p < SLGM_NUM_PORTS; p++) begin
            // Ports of older serializers never update, so outputs hold
            if (fwd_frame[p] && fwd_capable[p]) begin                      // R4
                if (fwd_fc_reg[p] + 3'h1 >= fwd_period(fwd_cnt_reg[p*3 +: 3])) begin // R5
                    fwd_fc_next[p]  = 3'h0;
                    fwd_val_next[p] = fwd_bits[p*4 +: 4];                   // R2
                end else begin
                    fwd_fc_next[p] = fwd_fc_reg[p] + 3'h1;                  // R19
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int p = 0; p < SLGM_NUM_PORTS; p++) begin
                fwd_val_reg[p] <= 4'h0;
                fwd_fc_reg[p]  <= 3'h0;
            end
        end else begin
            fwd_val_reg <= fwd_val_next;
            fwd_fc_reg  <= fwd_fc_next;
        end
    end

    // ****************************************************************
    // Local pin output mux
    // ****************************************************************
    logic [SLGM_NUM_PINS-1:0] pin_out_next, pin_oe_next;
    logic [SLGM_NUM_PINS-1:0] pin_out_reg, pin_oe_reg, ien_reg, pden_reg;

    always_comb begin
        for (int i = 0; i < SLGM_NUM_PINS; i++) begin
            pin_oe_next[i] = pin_cfg_reg[i][SLGM_CFG_OE];                   // R1
            unique case (pin_cfg_reg[i][SLGM_CFG_GRP_L +: 3])
                SLGM_GRP_PORT0: pin_out_next[i] = fwd_val_reg[0][pin_cfg_reg[i][SLGM_CFG_SUB_L +: 2]]; // R3
                SLGM_GRP_PORT1: pin_out_next[i] = fwd_val_reg[1][pin_cfg_reg[i][SLGM_CFG_SUB_L +: 2]]; // R3
                SLGM_GRP_STATUS: begin
                    if (pin_cfg_reg[i][SLGM_CFG_SUB_L +: 3] == SLGM_SUB_CONST) begin
                        pin_out_next[i] = pin_cfg_reg[i][SLGM_CFG_LVL];     // R18
                    end else if (pin_cfg_reg[i][SLGM_CFG_SUB_L +: 3] == SLGM_SUB_SYNC) begin
                        pin_out_next[i] = sensor_sync_pulse;                // R7
                    end else begin
                        pin_out_next[i] = 1'b0;
                    end
                end
                default: pin_out_next[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_out_reg <= 7'h00;
            pin_oe_reg  <= 7'h00;                                           // R8
            ien_reg     <= SLGM_EN_RESET;
            pden_reg    <= SLGM_EN_RESET;
        end else begin
            pin_out_reg <= pin_out_next;
            pin_oe_reg  <= pin_oe_next;
            ien_reg     <= ~in_dis_reg;                                     // R17
            pden_reg    <= ~pd_dis_reg;                                     // R17
        end
    end

    assign pin_out         = pin_out_reg;
    assign pin_oe          = pin_oe_reg;
    assign pin_input_en    = ien_reg;
    assign pin_pulldown_en = pden_reg;

    // ****************************************************************
    // Back channel frame timer and slot sampling
    // ****************************************************************
    // One frame is 30 bit times; bit time is bc_div clocks (1 = fastest)
    logic [4:0]  bit_cnt_reg, bit_cnt_next;
    logic [4:0]  div_cnt_reg, div_cnt_next;
    logic        bc_frame_next, bc_frame_reg;
    logic [7:0]  bc_bits_next, bc_bits_reg;
    logic        frame_end;
    logic [5:0]  frm_gap_reg, frm_gap_next;
    logic        frm_clean_reg, frm_clean_next;

    assign frame_end = (div_cnt_reg + 5'h01 >= bc_div_reg) && (bit_cnt_reg == 5'(SLGM_BC_FRAME_BITS - 1)); // R11

    always_comb begin
        div_cnt_next  = (div_cnt_reg + 5'h01 >= bc_div_reg) ? 5'h00 : div_cnt_reg + 5'h01;
        bit_cnt_next  = bit_cnt_reg;
        if (div_cnt_reg + 5'h01 >= bc_div_reg) begin
            bit_cnt_next = frame_end ? 5'h00 : bit_cnt_reg + 5'h01;         // R13
        end
        bc_frame_next = frame_end;
        frm_gap_next   = bc_frame_reg ? 6'h00 : (frm_gap_reg == 6'h3F) ? frm_gap_reg : frm_gap_reg + 6'h01;
        frm_clean_next = (bc_frame_reg || frm_clean_reg) && bc_div_reg == 5'h01;
        bc_bits_next  = bc_bits_reg;
        if (frame_end) begin
            for (int p = 0; p < SLGM_NUM_PORTS; p++) begin
                for (int s = 0; s < 2; s++) begin
                    // Each slot reads the pin bus independently, so pins may be shared
                    bc_bits_next[p*4+s]   = slot_src(bc_lo_reg[p][s*4 +: 4], pin_in & ien_reg, sensor_sync_pulse); // R9 R10 R15
                    bc_bits_next[p*4+s+2] = slot_src(bc_hi_reg[p][s*4 +: 4], pin_in & ien_reg, sensor_sync_pulse); // R9 R15
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_cnt_reg  <= 5'h00;
            div_cnt_reg  <= 5'h00;
            bc_frame_reg <= 1'b0;
            bc_bits_reg  <= 8'h00;
            frm_gap_reg   <= 6'h00;
            frm_clean_reg <= 1'b0;
        end else begin
            bit_cnt_reg  <= bit_cnt_next;
            div_cnt_reg  <= div_cnt_next;
            bc_frame_reg <= bc_frame_next;                                  // R12
            bc_bits_reg  <= bc_bits_next;                                   // R12
            frm_gap_reg   <= frm_gap_next;
            frm_clean_reg <= frm_clean_next;
        end
    end

    assign bc_frame = {SLGM_NUM_PORTS{bc_frame_reg}};
    assign bc_bits  = bc_bits_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_frame_period: assert property (@(posedge clk) disable iff (rst) // R11
        bc_frame_reg && frm_clean_reg |-> frm_gap_reg == 6'(SLGM_BC_FRAME_BITS - 1))
        else $error("back frame period not thirty bits");
    chk_oe_reset: assert property (@(posedge clk) disable iff (rst) // R8
        $fell(rst) |-> pin_oe == 7'h00)
        else $error("pins not input after reset");
    chk_bits_hold: assert property (@(posedge clk) disable iff (rst) // R12
        !bc_frame_reg |-> $stable(bc_bits_reg))
        else $error("back bits changed mid frame");
    chk_fwd_hold: assert property (@(posedge clk) disable iff (rst) // R19
        !fwd_frame[0] |=> $stable(fwd_val_reg[0]))
        else $error("forward value changed without frame");
    chk_old_port: assert property (@(posedge clk) disable iff (rst) // R4
        !fwd_capable[1] |=> $stable(fwd_val_reg[1]))
        else $error("older port updated forward value");
    chk_const_lvl: assert property (@(posedge clk) disable iff (rst) // R18
        pin_cfg_reg[1][6:1] == {SLGM_GRP_STATUS, SLGM_SUB_CONST} |=> pin_out[1] == $past(pin_cfg_reg[1][0]))
        else $error("constant level not driven");
    chk_in_en: assert property (@(posedge clk) disable iff (rst) // R17
        1'b1 |=> pin_input_en == ~$past(in_dis_reg))
        else $error("input enable mismatch");
    chk_oe_cfg: assert property (@(posedge clk) disable iff (rst) // R1
        1'b1 |=> pin_oe[2] == $past(pin_cfg_reg[2][7]))
        else $error("output enable mismatch");

endmodule : slgm_mapper

/* File: slgm_serializer_model.sv */
// Remote serializer model: forward frames out, back-channel slots in
`timescale 1ns/100ps
module slgm_serializer_model
    import slgm_pkg::*;
#(
    parameter int FRAME_GAP = 10
)
(
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      run,
    output logic      [SLGM_NUM_PORTS-1:0] fwd_frame,
    output logic      [7:0]                fwd_bits,
    input  wire logic [SLGM_NUM_PORTS-1:0] bc_frame,
    input  wire logic [7:0]                bc_bits,
    output logic      [7:0]                bc_seen
);
    int         gap_cnt;
    logic [7:0] val;

    // Bits mean nothing outside a frame pulse, so show the inverse there
    assign fwd_bits = (fwd_frame != 2'h0) ? val : ~val;

    // Every signal toggles each frame so that the sampling cadence shows at the pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_cnt   <= 0;
            fwd_frame <= '0;
            val       <= '0;
            bc_seen   <= '0;
        end else begin
            fwd_frame <= '0;
            if (run) begin
                gap_cnt <= (gap_cnt == FRAME_GAP - 1) ? 0 : gap_cnt + 1;
                if (gap_cnt == FRAME_GAP - 1) begin
                    fwd_frame <= '1;
                    val       <= ~val;
                end
            end
            if (bc_frame[0]) begin
                bc_seen <= bc_bits;
            end
        end
    end
endmodule : slgm_serializer_model

/* File: serial_link_gpio_mapper_tb.sv */
// Self-checking bench for the serial link pin mapper
`timescale 1ns/100ps
module serial_link_gpio_mapper_tb;
    import slgm_pkg::*;
    logic        clk, rst, hsel, hwrite, hreadyout, hresp, sync, run;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans, fwd_frame, fwd_capable, bc_frame;
    logic [2:0]  hsize;
    logic [6:0]  pin_in, pin_out, pin_oe, in_en, pd_en;
    logic [7:0]  fwd_bits, bc_bits, bc_seen;
    logic        prev;
    int          n_errors, total_checks, toggles, t0, gap;
    int          cnt_tab[5] = '{1, 2, 3, 4, 1};
    int          lo_tab[5]  = '{19, 0, 3, 3, 0};
    int          hi_tab[5]  = '{20, 1, 4, 4, 0};
    logic [6:0]  bp_tab[3]  = '{7'h09, 7'h60, 7'h60};
    logic [7:0]  bd_tab[3]  = '{8'h00, 8'h00, 8'h40};
    logic [7:0]  be_tab[3]  = '{8'h37, 8'hC8, 8'hC0};

    slgm_mapper i_slgm_mapper (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_input_en(in_en), .pin_pulldown_en(pd_en), .sensor_sync_pulse(sync), .fwd_frame(fwd_frame),
        .fwd_capable(fwd_capable), .fwd_bits(fwd_bits), .bc_frame(bc_frame), .bc_bits(bc_bits));
    slgm_serializer_model i_slgm_serializer_model (.clk(clk), .rst(rst), .run(run), .fwd_frame(fwd_frame),
        .fwd_bits(fwd_bits), .bc_frame(bc_frame), .bc_bits(bc_bits), .bc_seen(bc_seen));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Counts every change of pin 0 so that update cadence can be measured
    always @(posedge clk) begin
        prev <= pin_out[0];
        if (pin_out[0] !== prev) begin
            toggles <= toggles + 1;
        end
    end

    // ****************************************************************
    // Bus and compare tasks
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Register index times four is the byte address of its word
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= 3'h2;
        haddr  <= {22'h00_0000, idx, 2'h0};
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic wait_bc(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (bc_frame[0] !== 1'b1 && n < 500);
        if (n >= 500) begin
            n_errors++;
            $display("BAD back frame wait expected frame seen none");
        end
        @(posedge clk);
    endtask : wait_bc

    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        {hsel, hwrite, sync, run, htrans, hsize, haddr, hwdata} = '0;
        fwd_capable = 2'h3;
        pin_in      = 7'h00;
        rst         = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        check("oe at reset", 7'h00, pin_oe);
        check("input en at reset", 7'h7F, in_en);
        check("pulldown at reset", 7'h7F, pd_en);
        bus(0, SLGM_INPUT_CTL_ADDR, 0, q);
        check("input ctl reset", 32'h0000_0000, q);
        bus(0, SLGM_PIN_CFG0_ADDR, 0, q);
        check("pin cfg reset", SLGM_PIN_CFG_RST, q);
        bus(0, SLGM_BC_DIV_ADDR, 0, q);
        check("divider reset", SLGM_BC_DIV_RST, q);
        $display("TEST reset done");

        bus(1, SLGM_INPUT_CTL_ADDR, 32'h0000_0008, q);
        bus(1, SLGM_PD_CTL_ADDR, 32'h0000_007F, q);
        repeat (2) @(posedge clk);
        check("input en", 7'h77, in_en);
        check("pulldown en", 7'h00, pd_en);
        bus(0, SLGM_PD_CTL_ADDR, 0, q);
        check("pulldown readback", 32'h0000_007F, q);
        bus(0, 8'h30, 0, q);
        check("unmapped read", 32'h0000_0000, q);
        bus(1, SLGM_INPUT_CTL_ADDR, 32'h0000_0000, q);
        pin_in <= 7'h2A;
        bus(0, SLGM_STATUS_ADDR, 0, q);
        check("status pins", 7'h2A, q[6:0]);
        $display("TEST registers done");

        bus(1, SLGM_PIN_CFG0_ADDR + 8'h01, 32'h0000_00C1, q);
        repeat (2) @(posedge clk);
        check("level high", 1'b1, pin_out[1]);
        check("level oe", 1'b1, pin_oe[1]);
        bus(1, SLGM_PIN_CFG0_ADDR + 8'h01, 32'h0000_00C0, q);
        repeat (2) @(posedge clk);
        check("level low", 1'b0, pin_out[1]);
        bus(1, SLGM_PIN_CFG0_ADDR + 8'h02, 32'h0000_00C8, q);
        sync <= 1'b1;
        repeat (3) @(posedge clk);
        check("sync out high", 1'b1, pin_out[2]);
        sync <= 1'b0;
        repeat (3) @(posedge clk);
        check("sync out low", 1'b0, pin_out[2]);
        $display("TEST status sources done");

        // Pin 0 takes signal 2 of port 1
        bus(1, SLGM_PIN_CFG0_ADDR, 32'h0000_0094, q);
        repeat (2) @(posedge clk);
        check("fwd pin oe", 1'b1, pin_oe[0]);
        for (int i = 0; i < 5; i++) begin
            fwd_capable <= (i == 4) ? 2'h1 : 2'h3;
            bus(1, SLGM_FWD_CNT_ADDR, cnt_tab[i] << 3, q);
            t0 = toggles;
            run <= 1'b1;
            repeat (200) @(posedge clk);
            run <= 1'b0;
            repeat (10) @(posedge clk);
            total_checks++;
            if (toggles - t0 < lo_tab[i] || toggles - t0 > hi_tab[i]) begin
                n_errors++;
                $display("BAD fwd toggles expected %0d..%0d seen %0d", lo_tab[i], hi_tab[i], toggles - t0);
            end
        end
        $display("TEST forward cadence done");

        wait_bc(gap);
        wait_bc(gap);
        check("bc gap div1", 30, gap);
        bus(1, SLGM_BC_DIV_ADDR, 32'h0000_0002, q);
        wait_bc(gap);
        wait_bc(gap);
        check("bc gap div2", 60, gap);
        bus(1, SLGM_BC_DIV_ADDR, 32'h0000_0001, q);
        bus(1, SLGM_PORT_SEL_ADDR, 0, q);
        bus(1, SLGM_BC_SEL_LO_ADDR, 32'h0000_0033, q);
        bus(1, SLGM_BC_SEL_HI_ADDR, 32'h0000_0067, q);
        bus(1, SLGM_PORT_SEL_ADDR, 1, q);
        bus(1, SLGM_BC_SEL_LO_ADDR, 32'h0000_0070, q);
        bus(1, SLGM_BC_SEL_HI_ADDR, 32'h0000_0055, q);
        for (int i = 0; i < 3; i++) begin
            pin_in <= bp_tab[i];
            sync   <= (i == 0);
            bus(1, SLGM_INPUT_CTL_ADDR, bd_tab[i], q);
            wait_bc(gap);
            wait_bc(gap);
            @(posedge clk);
            check("bc slots", be_tab[i], bc_seen);
        end
        $display("TEST back channel done");
        wrap_up();
    end

    initial begin
        #200_000;
        n_errors++;
        wrap_up();
    end
endmodule : serial_link_gpio_mapper_tb
